// *** core/rst_cause_pkg.sv ***
// constants for the reset cause and state logic
package rst_cause_pkg;
  // register indices (printed offsets not all multiples of four: byte address = 4 * index)
  localparam logic [7:0] IDX_PROGRAM_COUNTER_LOW = 8'h02;
  localparam logic [7:0] IDX_STATUS_FLAGS = 8'h03;
  localparam logic [7:0] IDX_RESET_CONTROL = 8'h08;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h09;
  localparam logic [7:0] IDX_EVENT_MASK = 8'h0a;
  localparam logic [7:0] IDX_RESET_CAUSE = 8'h0b;
  localparam int ADDR_W = 10;
  // status field positions
  localparam int BIT_PIN_CHANGE_WAKE = 7;
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_POWER_DOWN = 3;
  // reset values
  localparam logic [7:0] PCL_RESET_VALUE = 8'hff;
  localparam logic [7:0] STATUS_POR_VALUE = 8'h98;
  // reset_control fields
  localparam int BIT_BROWNOUT_ENABLE = 0;
  localparam int BIT_RC_MODE = 1;
  // delay timer figures
  localparam int DELAY_LONG_MS = 18;
  localparam int DELAY_SHORT_MS = 1;
  localparam int TICK_US = 100;
  localparam int CLK_HZ = 20000000;
  localparam int TICK_CYCLES = (TICK_US * (CLK_HZ / 1000000));
  localparam int DELAY_LONG_TICKS = DELAY_LONG_MS * 1000 / TICK_US;
  localparam int DELAY_SHORT_TICKS = DELAY_SHORT_MS * 1000 / TICK_US;
  // cause encoding (one-hot, also reported in reset_cause)
  localparam int NUM_CAUSES = 7;
  localparam int C_POR = 0;
  localparam int C_MASTER_CLEAR_PIN_RUN = 1;
  localparam int C_MASTER_CLEAR_PIN_WAKE = 2;
  localparam int C_WDT_RUN = 3;
  localparam int C_WDT_WAKE = 4;
  localparam int C_PIN_WAKE = 5;
  localparam int C_BROWNOUT = 6;
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN = 3'b100
  } seq_state_e;
endpackage

// *** core/tick_divider.sv ***
// divider producing one-cycle tick pulses for the reset delay timer
`default_nettype none
module tick_divider
  import rst_cause_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic restart,
  output logic tick
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt_r;
  wire last = (cnt_r == CW'(DIV - 1));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      cnt_r <= (restart || last) ? '0 : cnt_r + 1'b1;
      tick <= last && !restart;
    end
  end
endmodule
`default_nettype wire

// *** core/reset_cause_and_state_logic.sv ***
// reset source handling, cause flags and reset delay sequencing
// Function
// - seven reset sources accepted: por, pin run/wake, watchdog run/wake, pin change, brownout.
// - reset-independent registers keep their value through every non power-on reset.
// - ordinary registers take reset values on power-on, pin or watchdog reset.
// - any wake from sleep restarts from the reset vector, not resuming.
// - status holds timeout bit 4, power-down bit 3, pin-change wake bit 7.
// - every reset loads counter low 0xff; power-on gives status 1001 1xxx.
// - pin reset while running clears status bits 6 and 5 only.
// - pin wake gives status 1001 0uuu.
// - watchdog reset while running gives status u000 1uuu.
// - watchdog wake gives status 1000 0uuu.
// - pin-change wake gives status 000u uuuu.
// - brownout clears bits 6 and 5; other bits undefined.
// - pin reset while running keeps timeout and power-down flags.
// - watchdog-clear instruction sets timeout and power-down flags.
// - delay timer holds core 18 ms; in rc mode 1 ms after first power-on.
// - every power-on reset forces the brownout enable off.
`default_nettype none
module reset_cause_and_state_logic
  import rst_cause_pkg::*;
#(
  parameter int LONG_TICKS = DELAY_LONG_TICKS,
  parameter int SHORT_TICKS = DELAY_SHORT_TICKS,
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst_b,
  // reset requests
  input wire logic master_clear_pin_b,
  input wire logic watchdog_timeout,
  input wire logic pin_change_wake,
  input wire logic brownout_detect,
  input wire logic core_sleeping,
  input wire logic watchdog_clear_instruction,
  // core side
  output logic core_reset,
  output logic core_reset_pulse,
  output logic brownout_enable_bit,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // interrupt
  output logic irq
);
  localparam int TW = $clog2(LONG_TICKS + 1);

  seq_state_e state_r, state_nxt;
  logic [TW-1:0] delay_r;
  logic [7:0] pcl_r;
  logic [7:0] status_r;
  logic [1:0] ctrl_r;
  logic [NUM_CAUSES-1:0] evt_r, mask_r, cause_r;
  logic por_done_r;
  logic tick;

  // register decode
  // byte addressed port, one register per word; misaligned accesses
  // select nothing, so writes drop and reads return zero
  wire word_ok = (reg_addr[1:0] == 2'b00);
  wire [7:0] idx = reg_addr[ADDR_W-1:2];
  wire sel_pcl = word_ok && (idx == IDX_PROGRAM_COUNTER_LOW);
  wire sel_status = word_ok && (idx == IDX_STATUS_FLAGS);
  wire sel_ctrl = word_ok && (idx == IDX_RESET_CONTROL);
  wire sel_evt = word_ok && (idx == IDX_EVENT_STATUS);
  wire sel_mask = word_ok && (idx == IDX_EVENT_MASK);
  wire sel_cause = word_ok && (idx == IDX_RESET_CAUSE);
  wire running = (state_r == ST_RUN);

  wire master_clear_pin_req = !master_clear_pin_b;
  wire bod_req = brownout_detect && ctrl_r[BIT_BROWNOUT_ENABLE];
  wire [NUM_CAUSES-1:0] req_vec;
  assign req_vec[C_POR] = 1'b0;
  assign req_vec[C_MASTER_CLEAR_PIN_RUN] = master_clear_pin_req && !core_sleeping;
  assign req_vec[C_MASTER_CLEAR_PIN_WAKE] = master_clear_pin_req && core_sleeping;
  assign req_vec[C_WDT_RUN] = watchdog_timeout && !core_sleeping;
  assign req_vec[C_WDT_WAKE] = watchdog_timeout && core_sleeping;
  assign req_vec[C_PIN_WAKE] = pin_change_wake && core_sleeping;
  assign req_vec[C_BROWNOUT] = bod_req;
  wire any_req = |req_vec;
  // only the first cycle of a request episode picks the cause
  // later requests inside the same hold only restart the delay, so a
  // bouncing pin cannot overwrite the cause software wants to see
  wire new_reset = any_req && running;

  // status rewrite per cause, priority brownout > pin > watchdog > pin change
  logic [7:0] status_cause;
  always_comb begin
    status_cause = status_r;
    if (req_vec[C_BROWNOUT]) begin
      status_cause[6:5] = 2'b00;
    end else if (req_vec[C_MASTER_CLEAR_PIN_WAKE]) begin
      status_cause[7:3] = 5'b10010;
    end else if (req_vec[C_MASTER_CLEAR_PIN_RUN]) begin
      status_cause[6:5] = 2'b00;
    end else if (req_vec[C_WDT_WAKE]) begin
      status_cause[7:3] = 5'b10000;
    end else if (req_vec[C_WDT_RUN]) begin
      status_cause[6:3] = 4'b0001;
    end else if (req_vec[C_PIN_WAKE]) begin
      status_cause[7:5] = 3'b000;
    end
  end
  // low bits stay as they were above

  wire [NUM_CAUSES-1:0] cause_pick;
  assign cause_pick[C_BROWNOUT] = req_vec[C_BROWNOUT];
  assign cause_pick[C_MASTER_CLEAR_PIN_WAKE] = req_vec[C_MASTER_CLEAR_PIN_WAKE] && !bod_req;
  assign cause_pick[C_MASTER_CLEAR_PIN_RUN] = req_vec[C_MASTER_CLEAR_PIN_RUN] && !bod_req;
  assign cause_pick[C_WDT_WAKE] = req_vec[C_WDT_WAKE] && !bod_req && !master_clear_pin_req;
  assign cause_pick[C_WDT_RUN] = req_vec[C_WDT_RUN] && !bod_req && !master_clear_pin_req;
  assign cause_pick[C_PIN_WAKE] = req_vec[C_PIN_WAKE] && !bod_req && !master_clear_pin_req && !watchdog_timeout;
  assign cause_pick[C_POR] = 1'b0;

  // delay length
  // short delay only once the first power-on delay has run out;
  // rc mode set before that still gets the long power-on delay
  wire [TW-1:0] delay_load = (ctrl_r[BIT_RC_MODE] && por_done_r) ? TW'(SHORT_TICKS) : TW'(LONG_TICKS);

  // sequencer
  // a request in delay goes back to hold, which reloads the counter:
  // a level that drops and returns restarts the full delay
  // hold while requested, then delay
  always_comb begin
    case (state_r)
      ST_HOLD: state_nxt = any_req ? ST_HOLD : ST_DELAY;
      ST_DELAY: state_nxt = any_req ? ST_HOLD : ((delay_r == '0) ? ST_RUN : ST_DELAY);
      ST_RUN: state_nxt = any_req ? ST_HOLD : ST_RUN;
      default: state_nxt = ST_HOLD;
    endcase
  end

  tick_divider #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .restart(state_r != ST_DELAY),
    .tick(tick)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // delay counter reloaded whenever a request re-enters hold
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      delay_r <= TW'(LONG_TICKS);
    end else if (state_r != ST_DELAY) begin
      delay_r <= delay_load;
    end else if (tick && delay_r != '0) begin
      delay_r <= delay_r - 1'b1;
    end
  end

  // marks that the first power-on delay has finished
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_done_r <= 1'b0;
    end else if (state_r == ST_DELAY && state_nxt == ST_RUN) begin
      por_done_r <= 1'b1;
    end
  end

  // core reset outputs; the pulse marks the first cycle of a new reset taken from run, not the release
  // wake requests reset the core like any other source
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_reset <= 1'b1;
      core_reset_pulse <= 1'b0;
    end else begin
      core_reset <= (state_nxt != ST_RUN);
      core_reset_pulse <= new_reset;
    end
  end

  // counter low forced on every reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pcl_r <= PCL_RESET_VALUE;
    end else if (any_req || !running) begin
      pcl_r <= PCL_RESET_VALUE;
    end else if (reg_write && sel_pcl) begin
      pcl_r <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= STATUS_POR_VALUE;
    end else if (new_reset) begin
      status_r <= status_cause;
    end else if (watchdog_clear_instruction && running) begin
      status_r[BIT_TIMEOUT] <= 1'b1;
      status_r[BIT_POWER_DOWN] <= 1'b1;
    end else if (reg_write && sel_status && running) begin
      // flags 7, 4, 3 are hardware owned
      status_r[6:5] <= reg_wdata[6:5];
      status_r[2:0] <= reg_wdata[2:0];
    end
  end

  // control register survives non power-on resets
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= 2'b00;
    end else if (reg_write && sel_ctrl) begin
      ctrl_r <= reg_wdata[1:0];
    end
  end
  // control survives pin, watchdog and brownout resets on purpose:
  // a brownout must not switch its own detector off
  wire brownout_enable_bit_w;
  assign brownout_enable_bit_w = ctrl_r[BIT_BROWNOUT_ENABLE];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      brownout_enable_bit <= 1'b0;
    end else begin
      brownout_enable_bit <= brownout_enable_bit_w;
    end
  end

  // cause record and mask reset on power-on only; mask survives later resets, cause reloads on each reset taken from run
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_r <= NUM_CAUSES'(1);
      mask_r <= '0;
    end else begin
      if (new_reset) begin
        cause_r <= cause_pick;
      end
      if (reg_write && sel_mask) begin
        mask_r <= reg_wdata[NUM_CAUSES-1:0];
      end
    end
  end

  // sticky events; a read clears, a new event in that cycle wins
  wire [NUM_CAUSES-1:0] evt_set = new_reset ? cause_pick : '0;
  wire evt_clr = reg_read && sel_evt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_r <= NUM_CAUSES'(1);
    end else begin
      evt_r <= (evt_clr ? '0 : evt_r) | evt_set;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_r & mask_r);
    end
  end

  // read mux, unmapped reads return zero
  // data zero outside the read cycle keeps the shared return bus quiet
  wire [31:0] rd_mux = sel_pcl ? {24'h000000, pcl_r} :
                       sel_status ? {24'h000000, status_r} :
                       sel_ctrl ? {30'h00000000, ctrl_r} :
                       sel_evt ? {25'h0000000, evt_r} :
                       sel_mask ? {25'h0000000, mask_r} :
                       sel_cause ? {25'h0000000, cause_r} : 32'h00000000;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// *** tb/rst_cause_monitor.sv ***
// concurrent checks on the reset cause block ports
`default_nettype none
module rst_cause_monitor
  import rst_cause_pkg::*;
#(
  parameter int SHORT_TICKS = DELAY_SHORT_TICKS,
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock, reset, requests
  input wire logic clk,
  input wire logic rst_b,
  input wire logic master_clear_pin_b,
  input wire logic watchdog_timeout,
  input wire logic core_sleeping,
  // core side
  input wire logic core_reset,
  input wire logic core_reset_pulse,
  input wire logic brownout_enable_bit,
  // register port and interrupt
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // cycles the core has been held so far
  int hold_cnt_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) hold_cnt_r <= 0;
    else if (core_reset) hold_cnt_r <= hold_cnt_r + 1;
    else hold_cnt_r <= 0;
  end
  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data not idle");
  chk_pulse_held: assert property (core_reset_pulse |-> core_reset)
    else $error("pulse outside reset");
  chk_pulse_single: assert property (core_reset_pulse |=> !core_reset_pulse)
    else $error("pulse too long");
  chk_request_holds: assert property ((!master_clear_pin_b || watchdog_timeout) |=> core_reset)
    else $error("core released under request");
  chk_delay_min: assert property ($fell(core_reset) |-> hold_cnt_r >= SHORT_TICKS * TICK_DIV)
    else $error("reset delay too short");
  chk_bod_copy: assert property (reg_write && reg_addr == 10'h020 && reg_wdata[0] |-> ##[1:2] brownout_enable_bit)
    else $error("brownout enable not set");
  chk_irq_masked: assert property (reg_write && reg_addr == 10'h028 && reg_wdata[6:0] == 7'h0 |-> ##2 !irq)
    else $error("irq with mask clear");
  chk_pcl_vector: assert property (reg_read && reg_addr == 10'h008 && core_reset |=> reg_rdata == 32'hff)
    else $error("counter low not at vector");
  cov_wake: cover property (core_sleeping && core_reset_pulse);
  cov_bod: cover property (brownout_enable_bit && core_reset_pulse);
  cov_irq: cover property ($rose(irq));
endmodule
bind reset_cause_and_state_logic rst_cause_monitor #(.SHORT_TICKS(SHORT_TICKS), .TICK_DIV(TICK_DIV)) mon (.clk, .rst_b,
  .master_clear_pin_b, .watchdog_timeout, .core_sleeping, .core_reset, .core_reset_pulse, .brownout_enable_bit,
  .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq);
`default_nettype wire

// *** tb/reset_source_model.sv ***
// model of the reset request sources around the block
`default_nettype none
module reset_source_model #(
  parameter int HOLD = 3
) (
  // bench control
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] sel,
  // request lines
  output logic master_clear_pin_b,
  output logic watchdog_timeout,
  output logic pin_change_wake,
  output logic brownout_detect
);
  timeunit 1ns;
  timeprecision 1ps;
  int left_r = 0;
  logic [1:0] sel_r = 2'h0;
  always_ff @(posedge clk) begin
    if (go) begin
      left_r <= HOLD;
      sel_r <= sel;
    end else if (left_r > 0) begin
      left_r <= left_r - 1;
    end
  end
  assign master_clear_pin_b = !(left_r > 0 && sel_r == 2'h0);
  assign watchdog_timeout = left_r > 0 && sel_r == 2'h1;
  assign pin_change_wake = left_r > 0 && sel_r == 2'h2;
  assign brownout_detect = left_r > 0 && sel_r == 2'h3;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// register-level bench for the reset cause block
`default_nettype none
module tb
  import rst_cause_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // shortened delay figures
  localparam int LONG = 6;
  localparam int DIV = 2;
  logic clk = 0, rst_b = 0, core_sleeping = 0, watchdog_clear_instruction = 0, reg_write = 0, reg_read = 0, go = 0;
  logic [1:0] sel = 2'h0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  wire logic master_clear_pin_b, watchdog_timeout, pin_change_wake, brownout_detect;
  wire logic core_reset, core_reset_pulse, brownout_enable_bit, irq;
  wire logic [31:0] reg_rdata;
  int fails = 0, compares = 0, held;
  reset_cause_and_state_logic #(.LONG_TICKS(LONG), .SHORT_TICKS(2), .TICK_DIV(DIV)) dut (.clk, .rst_b,
    .master_clear_pin_b, .watchdog_timeout, .pin_change_wake, .brownout_detect, .core_sleeping,
    .watchdog_clear_instruction, .core_reset, .core_reset_pulse, .brownout_enable_bit, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .irq);
  reset_source_model src (.clk, .go, .sel, .master_clear_pin_b, .watchdog_timeout, .pin_change_wake, .brownout_detect);
  initial forever #25 clk = ~clk;
  task automatic final_report;
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, exp, care = 32'hffffffff);
    compares++;
    if ((got & care) !== (exp & care)) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp & care, got & care);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] exp, care = 32'hffffffff);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    chk(n, reg_rdata, exp, care);
  endtask
  // counts held cycles; bounded so a stuck reset cannot hang
  task automatic wait_run(output int n);
    n = 0;
    repeat (300) begin
      @(negedge clk);
      if (core_reset === 1'b1) n++;
      else if (n > 0) break;
    end
  endtask
  task automatic event_reset(input logic [1:0] s, input logic slp, input logic [7:0] st, care, input int cause);
    @(posedge clk);
    core_sleeping <= slp;
    sel <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait_run(held);
    @(posedge clk);
    core_sleeping <= 1'b0;
    chk("irq_set", irq, 1);
    rd("status", 10'h00c, st, care);
    rd("event", 10'h024, 32'h1 << cause);
    rd("cause", 10'h02c, 32'h1 << cause);
    rd("pcl", 10'h008, 32'hff);
    chk("irq_clear", irq, 0);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    wait_run(held);
    chk("por_delay", held > LONG * DIV, 1);
    rd("status", 10'h00c, 32'h98, 32'hf8);
    rd("pcl", 10'h008, 32'hff);
    rd("cause", 10'h02c, 32'h01);
    rd("event", 10'h024, 32'h01);
    rd("event", 10'h024, 32'h00);
    rd("control", 10'h020, 32'h0);
    rd("unmapped", 10'h3fc, 32'h0);
    wr(10'h028, 32'h7f);
    chk("irq_idle", irq, 0);
    wr(10'h00c, 32'hff);
    rd("status", 10'h00c, 32'hff);
    event_reset(2'h1, 1'b0, 8'h8f, 8'hff, C_WDT_RUN);
    chk("long_delay", held > LONG * DIV, 1);
    wr(10'h00c, 32'h67);
    event_reset(2'h0, 1'b0, 8'h8f, 8'hff, C_MASTER_CLEAR_PIN_RUN);
    @(posedge clk);
    watchdog_clear_instruction <= 1'b1;
    @(posedge clk);
    watchdog_clear_instruction <= 1'b0;
    rd("status", 10'h00c, 32'h9f);
    event_reset(2'h0, 1'b1, 8'h97, 8'hff, C_MASTER_CLEAR_PIN_WAKE);
    event_reset(2'h1, 1'b1, 8'h87, 8'hff, C_WDT_WAKE);
    event_reset(2'h2, 1'b1, 8'h07, 8'hff, C_PIN_WAKE);
    wr(10'h020, 32'h3);
    repeat (2) @(negedge clk);
    chk("bod_on", brownout_enable_bit, 1);
    event_reset(2'h3, 1'b0, 8'h00, 8'h60, C_BROWNOUT);
    chk("short_delay", held < LONG * DIV, 1);
    wr(10'h028, 32'h0);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("bod_por", brownout_enable_bit, 0);
    rd("pcl_in_reset", 10'h008, 32'hff);
    rd("control", 10'h020, 32'h0);
    final_report;
  end
endmodule
`default_nettype wire
